// >>> dv/testbench.sv
// Purpose: self-checking bench of the skip-and-set execution block
// Assumes: the bench plays decoder and data memory, read data same cycle
// Notes:   inputs change on the falling edge, outputs are judged there
`timescale 1ns/10ps
`default_nettype none
`include "sksi_defines.svh"

module testbench
   import sksi_pkg::*;
;
   localparam int TIMEOUT_CYCLES = 3000;

   logic                     clock;
   logic                     rst_n;
   logic                     instr_valid;
   sksi_op_t                 instr_op;
   logic [`SKSI_BSEL_W-1:0]  bit_sel;
   logic [`SKSI_ADDR_W-1:0]  mem_addr;
   logic [`SKSI_DATA_W-1:0]  mem_rdata;
   logic                     mem_we;
   logic [`SKSI_ADDR_W-1:0]  mem_waddr;
   logic [`SKSI_DATA_W-1:0]  mem_wdata;
   logic                     accum_load;
   logic [`SKSI_DATA_W-1:0]  accumulator;
   logic                     dummy_cycle;
   logic                     instr_discard;
   logic                     pc_advance;
   logic [`SKSI_DATA_W-1:0]  acc_model;
   int                       n_errors;
   int                       n_tests;
   int                       cycles;

   sksi_exec dut_u (
      .clock         (clock),
      .rst_n         (rst_n),
      .instr_valid   (instr_valid),
      .instr_op      (instr_op),
      .bit_sel       (bit_sel),
      .mem_addr      (mem_addr),
      .mem_rdata     (mem_rdata),
      .mem_we        (mem_we),
      .mem_waddr     (mem_waddr),
      .mem_wdata     (mem_wdata),
      .accum_load    (accum_load),
      .accumulator   (accumulator),
      .dummy_cycle   (dummy_cycle),
      .instr_discard (instr_discard),
      .pc_advance    (pc_advance)
   );

   // ****************************************
   // clock and watchdog
   // ****************************************
   always #5 clock = ~clock;

   always @(posedge clock) begin
      cycles++;
      if (cycles == TIMEOUT_CYCLES) begin
         n_errors++;
         print_verdict();
      end
   end

   // ****************************************
   // compare and report
   // ****************************************
   task automatic chk1(input string name, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk8(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ****************************************
   // one instruction slot, then the slot after it
   // ****************************************
   // the slot after a taken skip is a set-ones: any write would show it
   task automatic exec_op(input sksi_op_t op, input logic [2:0] bs,
                          input logic [7:0] rd, input logic we,
                          input logic [7:0] wd, input logic ld,
                          input logic [7:0] res, input logic skip);
      logic [7:0] a;
      @(negedge clock);
      a = mem_addr + 8'h13;
      instr_valid = 1'h1;
      instr_op = op;
      bit_sel = bs;
      mem_addr = a;
      mem_rdata = rd;
      #1;
      chk1("pc_advance", 1'h1, pc_advance);
      @(negedge clock);
      instr_valid = skip;
      instr_op = OP_SET_MEM_ONES;
      mem_rdata = ~rd;
      if (ld) begin
         acc_model = res;
      end
      #1;
      chk1("mem_we", we, mem_we);
      chk1("accum_load", ld, accum_load);
      chk8("accumulator", acc_model, accumulator);
      chk1("dummy_cycle", skip, dummy_cycle);
      chk1("instr_discard", skip, instr_discard);
      chk1("pc_advance", skip, pc_advance);
      if (we) begin
         chk8("mem_wdata", wd, mem_wdata);
         chk8("mem_waddr", a, mem_waddr);
      end
      @(negedge clock);
      instr_valid = 1'h0;
      instr_op = OP_NONE;
      #1;
      chk1("mem_we", 1'h0, mem_we);
      chk1("dummy_cycle", 1'h0, dummy_cycle);
      chk8("accumulator", acc_model, accumulator);
      chk1("pc_advance", 1'h0, pc_advance);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      repeat (8) @(negedge clock);
      chk1("mem_we", 1'h0, mem_we);
      chk1("accum_load", 1'h0, accum_load);
      chk1("dummy_cycle", 1'h0, dummy_cycle);
      chk8("accumulator", `SKSI_ACC_RST, accumulator);
      chk8("mem_waddr", `SKSI_ADDR_RST, mem_waddr);
      chk8("mem_wdata", `SKSI_ZERO, mem_wdata);
      rst_n = 1'h1;
   endtask

   task automatic t_dec();
      exec_op(OP_DECREMENT_MEM_SKIP_ZERO, 3'h0, 8'h01,
              1'h1, 8'h00, 1'h0, 8'h00, 1'h1);
      exec_op(OP_DECREMENT_MEM_SKIP_ZERO, 3'h0, 8'h00,
              1'h1, 8'hFF, 1'h0, 8'h00, 1'h0);
      exec_op(OP_DECREMENT_MEM_SKIP_ZERO, 3'h0, 8'h80,
              1'h1, 8'h7F, 1'h0, 8'h00, 1'h0);
      exec_op(OP_DECREMENT_TO_ACC_SKIP_ZERO, 3'h0, 8'h01,
              1'h0, 8'h00, 1'h1, 8'h00, 1'h1);
      exec_op(OP_DECREMENT_TO_ACC_SKIP_ZERO, 3'h0, 8'h00,
              1'h0, 8'h00, 1'h1, 8'hFF, 1'h0);
      exec_op(OP_DECREMENT_TO_ACC_SKIP_ZERO, 3'h0, 8'h10,
              1'h0, 8'h00, 1'h1, 8'h0F, 1'h0);
   endtask

   task automatic t_inc();
      exec_op(OP_INCREMENT_MEM_SKIP_ZERO, 3'h0, 8'hFF,
              1'h1, 8'h00, 1'h0, 8'h00, 1'h1);
      exec_op(OP_INCREMENT_MEM_SKIP_ZERO, 3'h0, 8'h7F,
              1'h1, 8'h80, 1'h0, 8'h00, 1'h0);
      exec_op(OP_INCREMENT_MEM_SKIP_ZERO, 3'h0, 8'h00,
              1'h1, 8'h01, 1'h0, 8'h00, 1'h0);
      exec_op(OP_INCREMENT_TO_ACC_SKIP_ZERO, 3'h0, 8'hFF,
              1'h0, 8'h00, 1'h1, 8'h00, 1'h1);
      exec_op(OP_INCREMENT_TO_ACC_SKIP_ZERO, 3'h0, 8'h05,
              1'h0, 8'h00, 1'h1, 8'h06, 1'h0);
   endtask

   task automatic t_set();
      exec_op(OP_SET_MEM_ONES, 3'h0, 8'h5A,
              1'h1, 8'hFF, 1'h0, 8'h00, 1'h0);
      exec_op(OP_SET_MEM_ONES, 3'h0, 8'hFF,
              1'h1, 8'hFF, 1'h0, 8'h00, 1'h0);
      for (int i = 0; i < 8; i++) begin
         exec_op(OP_SET_MEM_BIT, 3'(i), 8'hA5,
                 1'h1, 8'hA5 | (8'h01 << i), 1'h0, 8'h00, 1'h0);
      end
   endtask

   task automatic t_skip_nonzero();
      exec_op(OP_SKIP_IF_OPERAND_NONZERO, 3'h0, 8'h00,
              1'h0, 8'h00, 1'h0, 8'h00, 1'h0);
      exec_op(OP_SKIP_IF_OPERAND_NONZERO, 3'h0, 8'h80,
              1'h0, 8'h00, 1'h0, 8'h00, 1'h1);
      for (int i = 0; i < 8; i++) begin
         exec_op(OP_SKIP_IF_BIT_NONZERO, 3'(i), 8'h01 << i,
                 1'h0, 8'h00, 1'h0, 8'h00, 1'h1);
         exec_op(OP_SKIP_IF_BIT_NONZERO, 3'(i), ~(8'h01 << i),
                 1'h0, 8'h00, 1'h0, 8'h00, 1'h0);
      end
      exec_op(OP_NONE, 3'h0, 8'h00,
              1'h0, 8'h00, 1'h0, 8'h00, 1'h0);
   endtask

   // slots back to back: three taken, then one that a skip discards
   task automatic t_back_to_back();
      @(negedge clock);
      instr_valid = 1'h1;
      instr_op = OP_INCREMENT_TO_ACC_SKIP_ZERO;
      mem_addr = 8'h3C;
      mem_rdata = 8'h41;
      @(negedge clock);
      acc_model = 8'h42;
      instr_op = OP_SET_MEM_ONES;
      mem_rdata = 8'h5A;
      #1;
      chk1("accum_load", 1'h1, accum_load);
      chk8("accumulator", acc_model, accumulator);
      chk1("mem_we", 1'h0, mem_we);
      chk1("dummy_cycle", 1'h0, dummy_cycle);
      @(negedge clock);
      instr_op = OP_DECREMENT_MEM_SKIP_ZERO;
      mem_rdata = 8'h01;
      #1;
      chk1("mem_we", 1'h1, mem_we);
      chk8("mem_wdata", `SKSI_ONES, mem_wdata);
      chk8("mem_waddr", 8'h3C, mem_waddr);
      chk1("accum_load", 1'h0, accum_load);
      @(negedge clock);
      instr_op = OP_INCREMENT_TO_ACC_SKIP_ZERO;
      mem_rdata = 8'h10;
      #1;
      chk1("mem_we", 1'h1, mem_we);
      chk8("mem_wdata", `SKSI_ZERO, mem_wdata);
      chk1("dummy_cycle", 1'h1, dummy_cycle);
      chk1("instr_discard", 1'h1, instr_discard);
      @(negedge clock);
      instr_valid = 1'h0;
      instr_op = OP_NONE;
      #1;
      chk1("mem_we", 1'h0, mem_we);
      chk1("accum_load", 1'h0, accum_load);
      chk8("accumulator", acc_model, accumulator);
      chk1("dummy_cycle", 1'h0, dummy_cycle);
   endtask

   initial begin
      clock = 1'h0;
      rst_n = 1'h0;
      instr_valid = 1'h0;
      instr_op = OP_NONE;
      bit_sel = 3'h0;
      mem_addr = 8'h00;
      mem_rdata = 8'h00;
      acc_model = `SKSI_ACC_RST;
      n_errors = 0;
      n_tests = 0;
      cycles = 0;
      t_reset();
      t_dec();
      t_inc();
      t_set();
      t_skip_nonzero();
      t_back_to_back();
      print_verdict();
   end
endmodule

`default_nettype wire

// >>> src/sksi_alu.sv
// Purpose: result, write targets and skip decision for one instruction
// Assumes: operand is the addressed data memory byte
// Notes:   no status flag is produced by any of these operations
`timescale 1ns/10ps
`default_nettype none
`include "sksi_defines.svh"

module sksi_alu
   import sksi_pkg::*;
(
   sksi_alu_if.alu bus
);

   logic [`SKSI_DATA_W-1:0] bit_mask;
   wire  [`SKSI_DATA_W-1:0] inc_val = bus.operand + `SKSI_ONE;
   wire  [`SKSI_DATA_W-1:0] dec_val = bus.operand - `SKSI_ONE;

   genvar i;
   for (i = 0; i < `SKSI_DATA_W; i++) begin : g_mask
      assign bit_mask[i] = (bus.bit_sel == `SKSI_BSEL_W'(i));
   end

   wire is_dec = (bus.op == OP_DECREMENT_MEM_SKIP_ZERO) ||
                 (bus.op == OP_DECREMENT_TO_ACC_SKIP_ZERO);
   wire is_inc = (bus.op == OP_INCREMENT_MEM_SKIP_ZERO) ||
                 (bus.op == OP_INCREMENT_TO_ACC_SKIP_ZERO);
   wire is_ones = (bus.op == OP_SET_MEM_ONES);
   wire is_bset = (bus.op == OP_SET_MEM_BIT);

   // ****************************************
   // result and targets
   // ****************************************
   assign bus.result = is_dec  ? dec_val :
                       is_inc  ? inc_val :
                       is_ones ? `SKSI_ONES :
                       is_bset ? (bus.operand | bit_mask)
                               : bus.operand;

   assign bus.mem_we = (bus.op == OP_DECREMENT_MEM_SKIP_ZERO) ||
                       (bus.op == OP_INCREMENT_MEM_SKIP_ZERO) ||
                       is_ones || is_bset;
   // accumulator forms leave the memory byte alone
   assign bus.accum_we = (bus.op == OP_DECREMENT_TO_ACC_SKIP_ZERO) ||
                         (bus.op == OP_INCREMENT_TO_ACC_SKIP_ZERO);

   // ****************************************
   // skip decision
   // ****************************************
   wire res_zero = (bus.result == `SKSI_ZERO);
   wire byte_nz  = (bus.operand != `SKSI_ZERO);
   wire bit_nz   = |(bus.operand & bit_mask);

   assign bus.skip =
      ((is_dec || is_inc) && res_zero) ||
      ((bus.op == OP_SKIP_IF_OPERAND_NONZERO) && byte_nz) ||
      ((bus.op == OP_SKIP_IF_BIT_NONZERO) && bit_nz);

endmodule

`default_nettype wire

// >>> src/sksi_alu_if.sv
// Purpose: carrier between the sequencer and the operand unit
// Assumes: purely combinational traffic on one clock
// Notes:   op is OP_NONE whenever nothing is to be executed
`timescale 1ns/10ps
`default_nettype none
`include "sksi_defines.svh"

interface sksi_alu_if;
   import sksi_pkg::*;
   sksi_op_t                  op;
   logic [`SKSI_DATA_W-1:0]   operand;
   logic [`SKSI_BSEL_W-1:0]   bit_sel;
   logic [`SKSI_DATA_W-1:0]   result;
   logic                      mem_we;
   logic                      accum_we;
   logic                      skip;

   modport alu  (input op, operand, bit_sel,
                 output result, mem_we, accum_we, skip);
   modport core (output op, operand, bit_sel,
                 input result, mem_we, accum_we, skip);
endinterface

`default_nettype wire

// >>> src/sksi_defines.svh
// Purpose: constants of the skip-and-set execution block
// Assumes: 8-bit data path, 8-bit data memory address
// Notes:   definitions only
`ifndef SKSI_DEFINES_SVH
`define SKSI_DEFINES_SVH

// ****************************************
// widths
// ****************************************
`define SKSI_DATA_W   8
`define SKSI_ADDR_W   8
`define SKSI_BSEL_W   3

// ****************************************
// data values
// ****************************************
`define SKSI_ZERO     8'h00
`define SKSI_ONE      8'h01
`define SKSI_ONES     8'hFF
`define SKSI_ACC_RST  8'h00
`define SKSI_ADDR_RST 8'h00

// ****************************************
// timing
// ****************************************
// cycles spent by a conditional instruction whose skip is taken
`define SKSI_SKIP_CYCLES 2

`endif

// >>> src/sksi_exec.sv
// Purpose: execution of the skip, set and skip-on-count instructions
// Assumes: mem_rdata holds the addressed byte in the cycle of instr_valid
// Notes:   one instruction slot per cycle; flags are never touched
//
// Overview of operation
// - decrement memory byte, write back, skip when new value zero
// - accumulator gets memory byte minus one, memory kept, skip on zero
// - a taken skip adds one dummy cycle, two cycles in total
// - non-zero result of decrement or increment means no skip
// - byte set writes FF to the addressed byte, no flags
// - bit set forces only the selected bit to one
// - increment memory byte, write back, skip when wrapped result zero
// - accumulator gets memory byte plus one, memory kept, skip on zero
// - skip-if-nonzero skips when the operand is not zero, no writes
`timescale 1ns/10ps
`default_nettype none
`include "sksi_defines.svh"

module sksi_exec
   import sksi_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   input  wire logic                    instr_valid,
   input  wire sksi_op_t                instr_op,
   input  wire logic [`SKSI_BSEL_W-1:0] bit_sel,
   input  wire logic [`SKSI_ADDR_W-1:0] mem_addr,
   input  wire logic [`SKSI_DATA_W-1:0] mem_rdata,
   output logic                         mem_we,
   output logic [`SKSI_ADDR_W-1:0]      mem_waddr,
   output logic [`SKSI_DATA_W-1:0]      mem_wdata,
   output logic                         accum_load,
   output logic [`SKSI_DATA_W-1:0]      accumulator,
   output logic                         dummy_cycle,
   output logic                         instr_discard,
   output logic                         pc_advance
);

   // ****************************************
   // state
   // ****************************************
   sksi_state_t             state_reg;
   sksi_state_t             state_next;
   logic                    mem_we_reg;
   logic [`SKSI_ADDR_W-1:0] mem_waddr_reg;
   logic [`SKSI_DATA_W-1:0] mem_wdata_reg;
   logic                    accum_load_reg;
   logic [`SKSI_DATA_W-1:0] accumulator_reg;
   logic [`SKSI_DATA_W-1:0] accumulator_next;

   sksi_alu_if alu_bus ();

   sksi_alu u_alu (
      .bus (alu_bus)
   );

   // ****************************************
   // issue
   // ****************************************
   // the slot after a taken skip carries the skipped instruction
   wire in_dummy = (state_reg == SKSI_DUMMY);
   wire take     = instr_valid && !in_dummy;

   assign alu_bus.op      = take ? instr_op : OP_NONE;
   assign alu_bus.operand = mem_rdata;
   assign alu_bus.bit_sel = bit_sel;

   wire do_mem   = alu_bus.mem_we;
   wire do_accum = alu_bus.accum_we;
   wire do_skip  = alu_bus.skip;

   always_comb begin
      state_next = SKSI_EXEC;
      unique case (state_reg)
         SKSI_EXEC:  state_next = do_skip ? SKSI_DUMMY
                                          : SKSI_EXEC;
         SKSI_DUMMY: state_next = SKSI_EXEC;
      endcase
   end

   assign accumulator_next = do_accum ? alu_bus.result
                                      : accumulator_reg;

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg <= SKSI_EXEC;
      end else begin
         state_reg <= state_next;
      end
   end

   // write strobe is a one-cycle pulse; a discarded slot never writes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mem_we_reg     <= 1'b0;
         accum_load_reg <= 1'b0;
      end else begin
         mem_we_reg     <= do_mem;
         accum_load_reg <= do_accum;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         mem_waddr_reg <= `SKSI_ADDR_RST;
         mem_wdata_reg <= `SKSI_ZERO;
      end else if (do_mem) begin
         mem_waddr_reg <= mem_addr;
         mem_wdata_reg <= alu_bus.result;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         accumulator_reg <= `SKSI_ACC_RST;
      end else begin
         accumulator_reg <= accumulator_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign mem_we        = mem_we_reg;
   assign mem_waddr     = mem_waddr_reg;
   assign mem_wdata     = mem_wdata_reg;
   assign accum_load    = accum_load_reg;
   assign accumulator   = accumulator_reg;
   assign dummy_cycle   = in_dummy;
   assign instr_discard = instr_valid && in_dummy;
   // executed and discarded slots both move the pc on
   assign pc_advance    = instr_valid;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   wire [`SKSI_DATA_W-1:0] rd_dec = mem_rdata - `SKSI_ONE;
   wire [`SKSI_DATA_W-1:0] rd_inc = mem_rdata + `SKSI_ONE;

   property p_dec_mem;
      take && instr_op == OP_DECREMENT_MEM_SKIP_ZERO |=>
         mem_we && mem_wdata == $past(rd_dec) &&
         mem_waddr == $past(mem_addr) &&
         (dummy_cycle == ($past(rd_dec) == `SKSI_ZERO));
   endproperty
   a_dec_mem: assert property (p_dec_mem)
      else $error("decrement to memory wrong");

   property p_dec_accum;
      take && instr_op == OP_DECREMENT_TO_ACC_SKIP_ZERO |=>
         !mem_we && accum_load && accumulator == $past(rd_dec) &&
         (dummy_cycle == (accumulator == `SKSI_ZERO));
   endproperty
   a_dec_accum: assert property (p_dec_accum)
      else $error("decrement to accumulator wrong");

   sequence s_skip_taken;
      !dummy_cycle ##1 dummy_cycle;
   endsequence

   property p_two_cycles;
      s_skip_taken |=> !dummy_cycle;
   endproperty
   a_two_cycles: assert property (p_two_cycles)
      else $error("dummy cycle not exactly one");

   property p_no_skip;
      take && instr_op == OP_INCREMENT_MEM_SKIP_ZERO &&
         mem_rdata != `SKSI_ONES |=> !dummy_cycle;
   endproperty
   a_no_skip: assert property (p_no_skip)
      else $error("skip on non-zero result");

   property p_set_ones;
      take && instr_op == OP_SET_MEM_ONES |=>
         mem_we && mem_wdata == `SKSI_ONES && !dummy_cycle;
   endproperty
   a_set_ones: assert property (p_set_ones)
      else $error("byte set did not write all ones");

   property p_set_bit;
      take && instr_op == OP_SET_MEM_BIT |=>
         mem_we && mem_wdata[$past(bit_sel)] &&
         ((mem_wdata ^ $past(mem_rdata)) &
          ~(`SKSI_ONE << $past(bit_sel))) == `SKSI_ZERO;
   endproperty
   a_set_bit: assert property (p_set_bit)
      else $error("bit set touched other bits");

   property p_inc_mem;
      take && instr_op == OP_INCREMENT_MEM_SKIP_ZERO |=>
         mem_we && mem_wdata == $past(rd_inc) && !accum_load &&
         (dummy_cycle == ($past(mem_rdata) == `SKSI_ONES));
   endproperty
   a_inc_mem: assert property (p_inc_mem)
      else $error("increment to memory wrong");

   property p_inc_accum;
      take && instr_op == OP_INCREMENT_TO_ACC_SKIP_ZERO |=>
         !mem_we && accumulator == $past(rd_inc) &&
         (dummy_cycle == (accumulator == `SKSI_ZERO));
   endproperty
   a_inc_accum: assert property (p_inc_accum)
      else $error("increment to accumulator wrong");

   property p_nonzero;
      take && instr_op == OP_SKIP_IF_OPERAND_NONZERO |=>
         !mem_we && !accum_load &&
         (dummy_cycle == ($past(mem_rdata) != `SKSI_ZERO));
   endproperty
   a_nonzero: assert property (p_nonzero)
      else $error("skip on non-zero operand wrong");

   property p_discard;
      dummy_cycle && instr_valid |=>
         !mem_we && !accum_load && !dummy_cycle &&
         $stable(accumulator);
   endproperty
   a_discard: assert property (p_discard)
      else $error("skipped instruction had an effect");

   c_dec_skip: cover property (take &&
      instr_op == OP_DECREMENT_MEM_SKIP_ZERO &&
      mem_rdata == `SKSI_ONE ##1 instr_discard);
   c_inc_accum_skip: cover property (take &&
      instr_op == OP_INCREMENT_TO_ACC_SKIP_ZERO &&
      mem_rdata == `SKSI_ONES ##1 dummy_cycle);
   c_bit_skip: cover property (take &&
      instr_op == OP_SKIP_IF_BIT_NONZERO ##1 dummy_cycle);
   c_back_to_back: cover property (take ##1 take ##1 take);

endmodule

`default_nettype wire

// >>> src/sksi_pkg.sv
// Purpose: types of the skip-and-set execution block
// Assumes: the decoder hands over one of these codes per instruction
// Notes:   OP_NONE stands for any instruction handled elsewhere
package sksi_pkg;

   typedef enum logic [3:0] {
      OP_NONE,
      OP_DECREMENT_MEM_SKIP_ZERO,
      OP_DECREMENT_TO_ACC_SKIP_ZERO,
      OP_SET_MEM_ONES,
      OP_SET_MEM_BIT,
      OP_INCREMENT_MEM_SKIP_ZERO,
      OP_INCREMENT_TO_ACC_SKIP_ZERO,
      OP_SKIP_IF_OPERAND_NONZERO,
      OP_SKIP_IF_BIT_NONZERO
   } sksi_op_t;

   typedef enum logic {
      SKSI_EXEC,
      SKSI_DUMMY
   } sksi_state_t;

endpackage
